// *** verilog/hdl_pkg.sv ***
// constants, types and helpers shared by the haptic drive limit register bank
package hdl_pkg;

    // register byte offsets on the serial bus
    localparam logic [7:0] HDL_ADDR_FEEDBACK_CONTROL = 8'h23;
    localparam logic [7:0] HDL_ADDR_STEADY_CLAMP     = 8'h24;
    localparam logic [7:0] HDL_ADDR_LOW_BAT_ONE      = 8'h25;
    localparam logic [7:0] HDL_ADDR_LOW_BAT_TWO      = 8'h26;

    // reset values
    localparam logic [7:0] HDL_RST_FEEDBACK_CONTROL  = 8'h36;
    localparam logic [7:0] HDL_RST_STEADY_CLAMP      = 8'h64;
    localparam logic [7:0] HDL_RST_LOW_BAT_ONE       = 8'h80;
    localparam logic [7:0] HDL_RST_LOW_BAT_TWO       = 8'h00;
    localparam logic [7:0] HDL_RST_UNMAPPED          = 8'h00;

    // field positions inside the feedback control register
    localparam int HDL_GAIN_LSB  = 0;
    localparam int HDL_SPEED_LSB = 2;

    // gain in hundredths, indexed by code
    localparam logic [11:0] HDL_GAIN_RES_0 = 12'h1f4;
    localparam logic [11:0] HDL_GAIN_RES_1 = 12'h3e8;
    localparam logic [11:0] HDL_GAIN_RES_2 = 12'h7d0;
    localparam logic [11:0] HDL_GAIN_RES_3 = 12'hbb8;
    localparam logic [11:0] HDL_GAIN_ECC_0 = 12'h022;
    localparam logic [11:0] HDL_GAIN_ECC_1 = 12'h069;
    localparam logic [11:0] HDL_GAIN_ECC_2 = 12'h0b6;
    localparam logic [11:0] HDL_GAIN_ECC_3 = 12'h190;

    // bits per serial byte, ack slot not counted
    localparam logic [3:0] HDL_BYTE_BITS = 4'h8;

    typedef enum logic [1:0] {
        HDL_SPEED_VERY_SLOW,
        HDL_SPEED_SLOW,
        HDL_SPEED_FAST,
        HDL_SPEED_VERY_FAST
    } hdl_speed_e;

    // which limit is currently in force on the output
    typedef enum logic [1:0] {
        HDL_SRC_OVERDRIVE,
        HDL_SRC_LOW_BAT_ONE,
        HDL_SRC_LOW_BAT_TWO,
        HDL_SRC_STEADY
    } hdl_src_e;

    function automatic logic [7:0] hdl_min8(input logic [7:0] a, input logic [7:0] b);
        hdl_min8 = (a < b) ? a : b;
    endfunction

endpackage

// *** verilog/hdl_clamp_select.sv ***
// effective output clamp selection from register limits and battery state
`timescale 1ns/1ps
`default_nettype none
module hdl_clamp_select
    import hdl_pkg::*;
(
    input  wire logic [7:0] steady_drive_limit,
    input  wire logic [7:0] overdrive_limit,
    input  wire logic [7:0] low_battery_limit_one,
    input  wire logic [7:0] low_battery_limit_two,
    input  wire logic       below_one,
    input  wire logic       below_two,
    input  wire logic       cal_or_diag,
    input  wire logic       overdrive_phase,
    output logic [7:0]      clamp,
    output hdl_src_e        source
);
    logic [7:0] od_eff;
    hdl_src_e   od_src;

    always_comb begin
        od_eff = overdrive_limit;
        od_src = HDL_SRC_OVERDRIVE;
        if (!cal_or_diag) begin
            if (below_two) begin
                od_eff = low_battery_limit_two;
                od_src = HDL_SRC_LOW_BAT_TWO;
            end else if (below_one) begin
                od_eff = low_battery_limit_one;
                od_src = HDL_SRC_LOW_BAT_ONE;
            end
        end
        if (overdrive_phase) begin
            clamp  = od_eff;
            source = od_src;
        end else if (od_eff < steady_drive_limit) begin
            clamp  = hdl_min8(od_eff, steady_drive_limit);
            source = od_src;
        end else begin
            clamp  = steady_drive_limit;
            source = HDL_SRC_STEADY;
        end
    end
endmodule
`default_nettype wire

// *** verilog/hdl_serial_slave.sv ***
// two-wire serial register slave: synchronised pins, byte framing, register pointer
`timescale 1ns/1ps
`default_nettype none
module hdl_serial_slave
    import hdl_pkg::*;
#(
    // arbitrary bus address, not tied to any real part
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    output logic [7:0]      reg_ptr,
    input  wire logic [7:0] reg_rdata,
    output logic            wr_stb,
    output logic [7:0]      wr_data
);
    typedef enum logic [2:0] {HDL_IDLE, HDL_RX, HDL_ACK, HDL_TX, HDL_TXACK} hdl_bus_e;
    typedef enum logic [1:0] {HDL_PH_ADDR, HDL_PH_REG, HDL_PH_DATA} hdl_phase_e;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        hdl_bus_e   st;
        hdl_phase_e ph;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic       rw;
        logic       mack;
        logic [7:0] ptr;
        logic       oe_n;
        logic       stb;
        logic [7:0] wdat;
    } hdl_slave_s;

    hdl_slave_s q, d;
    logic scl, sda, scl_rise, scl_fall, start, stop;

    assign scl      = q.scl_s[1];
    assign sda      = q.sda_s[1];
    assign scl_rise = q.scl_s[1] && !q.scl_s[2];
    assign scl_fall = !q.scl_s[1] && q.scl_s[2];
    assign start    = scl && q.scl_s[2] && !sda && q.sda_s[2];
    assign stop     = scl && q.scl_s[2] && sda && !q.sda_s[2];

    always_comb begin
        d       = q;
        d.stb   = 1'b0;
        // stage 0 feeds only stage 1
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        if (start) begin
            d.st   = HDL_RX;
            d.ph   = HDL_PH_ADDR;
            d.bitc = 4'h0;
            d.oe_n = 1'b1;
        end else if (stop) begin
            d.st   = HDL_IDLE;
            d.oe_n = 1'b1;
        end else if (scl_rise) begin
            if (q.st == HDL_RX) begin
                d.sh   = {q.sh[6:0], sda};
                d.bitc = q.bitc + 4'h1;
            end else if (q.st == HDL_TXACK) begin
                d.mack = !sda;
            end
        end else if (scl_fall) begin
            unique case (q.st)
                HDL_IDLE: ;
                HDL_RX: begin
                    if (q.bitc == HDL_BYTE_BITS) begin
                        d.bitc = 4'h0;
                        d.st   = HDL_ACK;
                        d.oe_n = 1'b0;
                        unique case (q.ph)
                            HDL_PH_ADDR: begin
                                d.rw = q.sh[0];
                                if (q.sh[7:1] != DEV_ADDR) begin
                                    d.st   = HDL_IDLE;
                                    d.oe_n = 1'b1;
                                end
                            end
                            HDL_PH_REG: d.ptr = q.sh;
                            default: begin
                                d.stb  = 1'b1;
                                d.wdat = q.sh;
                            end
                        endcase
                    end
                end
                HDL_ACK: begin
                    if (q.ph == HDL_PH_DATA) begin
                        d.ptr = q.ptr + 8'h01;
                    end
                    if (q.ph == HDL_PH_ADDR && q.rw) begin
                        d.st   = HDL_TX;
                        d.sh   = reg_rdata;
                        d.oe_n = reg_rdata[7];
                        d.bitc = 4'h1;
                        d.ptr  = q.ptr + 8'h01;
                    end else begin
                        d.st   = HDL_RX;
                        d.oe_n = 1'b1;
                        d.ph   = (q.ph == HDL_PH_ADDR) ? HDL_PH_REG : HDL_PH_DATA;
                    end
                end
                HDL_TX: begin
                    if (q.bitc == HDL_BYTE_BITS) begin
                        d.st   = HDL_TXACK;
                        d.oe_n = 1'b1;
                    end else begin
                        d.sh   = {q.sh[6:0], 1'b0};
                        d.oe_n = q.sh[6];
                        d.bitc = q.bitc + 4'h1;
                    end
                end
                HDL_TXACK: begin
                    if (q.mack) begin
                        d.st   = HDL_TX;
                        d.sh   = reg_rdata;
                        d.oe_n = reg_rdata[7];
                        d.bitc = 4'h1;
                        d.ptr  = q.ptr + 8'h01;
                    end else begin
                        d.st = HDL_IDLE;
                    end
                end
                default: d.st = HDL_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.st    <= HDL_IDLE;
            q.ph    <= HDL_PH_ADDR;
            q.bitc  <= 4'h0;
            q.sh    <= 8'h00;
            q.rw    <= 1'b0;
            q.mack  <= 1'b0;
            q.ptr   <= 8'h00;
            q.oe_n  <= 1'b1;
            q.stb   <= 1'b0;
            q.wdat  <= 8'h00;
        end else if (ce) begin
            q <= d;
        end
    end

    // open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_n = q.oe_n;
    assign reg_ptr  = q.ptr;
    assign wr_stb   = q.stb && ce;
    assign wr_data  = q.wdat;
endmodule
`default_nettype wire

// *** verilog/hdl_drive_limit_regs.sv ***
// haptic drive limit register bank with gain decode and clamp output
`timescale 1ns/1ps
`default_nettype none
module hdl_drive_limit_regs
    import hdl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    input  wire logic       eccentric_mass_actuator,
    input  wire logic       calibration_active,
    input  wire logic       diagnostics_active,
    input  wire logic       cal_gain_wr,
    input  wire logic [1:0] cal_gain_code,
    input  wire logic       overdrive_phase,
    input  wire logic [7:0] overdrive_limit,
    input  wire logic [7:0] battery_voltage_sense,
    input  wire logic [7:0] battery_threshold_one,
    input  wire logic [7:0] battery_threshold_two,
    output logic [1:0]      back_emf_amp_gain,
    output logic [11:0]     back_emf_gain_x100,
    output logic [1:0]      feedback_loop_speed,
    output logic [7:0]      drive_clamp,
    output logic [1:0]      clamp_source
);
    typedef struct packed {
        logic [7:0]  feedback_control;
        logic [7:0]  steady_drive_clamp;
        logic [7:0]  low_battery_clamp_one;
        logic [7:0]  low_battery_clamp_two;
        logic [1:0]  gain;
        logic [11:0] gain_x100;
        logic [1:0]  speed;
        logic [7:0]  clamp;
        hdl_src_e    src;
    } hdl_regs_s;

    hdl_regs_s  q, d;
    logic [7:0] reg_ptr;
    logic [7:0] reg_rdata;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [7:0] clamp_next;
    hdl_src_e   src_next;
    logic       below_one;
    logic       below_two;

    function automatic logic [11:0] gain_hundredths(input logic ecc, input logic [1:0] code);
        logic [11:0] g;
        g = 12'h000;
        unique case (code)
            2'h0: g = ecc ? HDL_GAIN_ECC_0 : HDL_GAIN_RES_0;
            2'h1: g = ecc ? HDL_GAIN_ECC_1 : HDL_GAIN_RES_1;
            2'h2: g = ecc ? HDL_GAIN_ECC_2 : HDL_GAIN_RES_2;
            2'h3: g = ecc ? HDL_GAIN_ECC_3 : HDL_GAIN_RES_3;
        endcase
        return g;
    endfunction

    hdl_serial_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_serial (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .ce        (ce),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oe_n  (sda_oe_n),
        .reg_ptr   (reg_ptr),
        .reg_rdata (reg_rdata),
        .wr_stb    (wr_stb),
        .wr_data   (wr_data)
    );

    // battery sense and thresholds come from same-clock logic
    assign below_one = battery_voltage_sense < battery_threshold_one;
    assign below_two = battery_voltage_sense < battery_threshold_two;

    hdl_clamp_select u_clamp (
        .steady_drive_limit    (q.steady_drive_clamp),
        .overdrive_limit       (overdrive_limit),
        .low_battery_limit_one (q.low_battery_clamp_one),
        .low_battery_limit_two (q.low_battery_clamp_two),
        .below_one             (below_one),
        .below_two             (below_two),
        .cal_or_diag           (calibration_active || diagnostics_active),
        .overdrive_phase       (overdrive_phase),
        .clamp                 (clamp_next),
        .source                (src_next)
    );

    // unmapped offsets read zero and ignore writes
    always_comb begin
        unique case (reg_ptr)
            HDL_ADDR_FEEDBACK_CONTROL: reg_rdata = q.feedback_control;
            HDL_ADDR_STEADY_CLAMP:     reg_rdata = q.steady_drive_clamp;
            HDL_ADDR_LOW_BAT_ONE:      reg_rdata = q.low_battery_clamp_one;
            HDL_ADDR_LOW_BAT_TWO:      reg_rdata = q.low_battery_clamp_two;
            default:                   reg_rdata = HDL_RST_UNMAPPED;
        endcase
    end

    always_comb begin
        d = q;
        if (cal_gain_wr) begin
            d.feedback_control[HDL_GAIN_LSB +: 2] = cal_gain_code;
        end
        // software write lands last, so a same-cycle user value is the one kept
        if (wr_stb) begin
            unique case (reg_ptr)
                HDL_ADDR_FEEDBACK_CONTROL: d.feedback_control = wr_data;
                HDL_ADDR_STEADY_CLAMP:     d.steady_drive_clamp = wr_data;
                HDL_ADDR_LOW_BAT_ONE:      d.low_battery_clamp_one = wr_data;
                HDL_ADDR_LOW_BAT_TWO:      d.low_battery_clamp_two = wr_data;
                default: ;
            endcase
        end
        d.gain = q.feedback_control[HDL_GAIN_LSB +: 2];
        d.gain_x100 = gain_hundredths(eccentric_mass_actuator, q.feedback_control[HDL_GAIN_LSB +: 2]);
        d.speed = q.feedback_control[HDL_SPEED_LSB +: 2];
        d.clamp = clamp_next;
        d.src   = src_next;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q.feedback_control      <= HDL_RST_FEEDBACK_CONTROL;
            q.steady_drive_clamp    <= HDL_RST_STEADY_CLAMP;
            q.low_battery_clamp_one <= HDL_RST_LOW_BAT_ONE;
            q.low_battery_clamp_two <= HDL_RST_LOW_BAT_TWO;
            q.gain                  <= HDL_RST_FEEDBACK_CONTROL[HDL_GAIN_LSB +: 2];
            q.gain_x100             <= HDL_GAIN_RES_2;
            q.speed                 <= HDL_RST_FEEDBACK_CONTROL[HDL_SPEED_LSB +: 2];
            q.clamp                 <= HDL_RST_UNMAPPED;
            q.src                   <= HDL_SRC_OVERDRIVE;
        end else if (ce) begin
            q <= d;
        end
    end

    assign back_emf_amp_gain   = q.gain;
    assign back_emf_gain_x100  = q.gain_x100;
    assign feedback_loop_speed = q.speed;
    assign drive_clamp         = q.clamp;
    assign clamp_source        = q.src;
endmodule
`default_nettype wire

// *** bench/hdl_drive_limit_regs_checker.sv ***
// port assertions for the haptic drive limit register bank
`timescale 1ns/1ps
`default_nettype none
module hdl_drive_limit_regs_checker (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic        eccentric_mass_actuator,
    input wire logic        calibration_active,
    input wire logic        diagnostics_active,
    input wire logic        cal_gain_wr,
    input wire logic [1:0]  cal_gain_code,
    input wire logic        overdrive_phase,
    input wire logic [7:0]  overdrive_limit,
    input wire logic [7:0]  battery_voltage_sense,
    input wire logic [7:0]  battery_threshold_one,
    input wire logic [7:0]  battery_threshold_two,
    input wire logic [1:0]  back_emf_amp_gain,
    input wire logic [11:0] back_emf_gain_x100,
    input wire logic [1:0]  feedback_loop_speed,
    input wire logic [7:0]  drive_clamp,
    input wire logic [1:0]  clamp_source
);
    localparam logic [11:0] GAIN_T [8] = '{12'h1f4, 12'h3e8, 12'h7d0, 12'hbb8, 12'h022, 12'h069, 12'h0b6, 12'h190};
    logic quiet;
    logic low_one;
    logic low_two;
    // battery clamps only count outside calibration and diagnostics
    assign quiet   = !(calibration_active || diagnostics_active);
    assign low_one = quiet && (battery_voltage_sense < battery_threshold_one);
    assign low_two = quiet && (battery_voltage_sense < battery_threshold_two);

    default clocking cb @(posedge sys_clk); endclocking
    // a frozen clock enable holds everything, so nothing is judged then
    default disable iff (srst || !ce);

    reset_values_a:
    assert property (disable iff (1'b0) srst && ce |=> drive_clamp == 8'h00 && clamp_source == 2'h0
        && back_emf_amp_gain == 2'h2 && feedback_loop_speed == 2'h1) else $error("reset values wrong");
    gain_decode_a:
    assert property (!$past(srst) && $past(ce) |-> back_emf_gain_x100 ==
        GAIN_T[{$past(eccentric_mass_actuator), back_emf_amp_gain}]) else $error("gain decode wrong");
    cal_gain_a:
    assert property (cal_gain_wr |=> ##1 back_emf_amp_gain == $past(cal_gain_code, 2))
        else $error("calibration gain not taken");
    od_phase_a:
    assert property (overdrive_phase && !low_one && !low_two |=> drive_clamp == $past(overdrive_limit)
        && clamp_source == 2'h0) else $error("overdrive clamp wrong");
    bat_two_a:
    assert property (overdrive_phase && low_two |=> clamp_source == 2'h2) else $error("second battery clamp unused");
    bat_one_a:
    assert property (overdrive_phase && low_one && !low_two |=> clamp_source == 2'h1)
        else $error("first battery clamp unused");
    steady_cap_a:
    assert property (!overdrive_phase && !low_one && !low_two |=> drive_clamp <= $past(overdrive_limit)
        && (clamp_source == 2'h3 || (clamp_source == 2'h0 && drive_clamp == $past(overdrive_limit))))
        else $error("steady clamp above overdrive limit");
    bat_steady_a:
    assert property (!overdrive_phase && low_two |=> clamp_source inside {2'h2, 2'h3})
        else $error("steady clamp ignores battery clamp");
endmodule

bind hdl_drive_limit_regs hdl_drive_limit_regs_checker u_checker (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .eccentric_mass_actuator(eccentric_mass_actuator),
    .calibration_active(calibration_active), .diagnostics_active(diagnostics_active),
    .cal_gain_wr(cal_gain_wr), .cal_gain_code(cal_gain_code), .overdrive_phase(overdrive_phase),
    .overdrive_limit(overdrive_limit), .battery_voltage_sense(battery_voltage_sense),
    .battery_threshold_one(battery_threshold_one), .battery_threshold_two(battery_threshold_two),
    .back_emf_amp_gain(back_emf_amp_gain), .back_emf_gain_x100(back_emf_gain_x100),
    .feedback_loop_speed(feedback_loop_speed), .drive_clamp(drive_clamp), .clamp_source(clamp_source)
);
`default_nettype wire

// *** bench/test_haptic_drive_limit_registers.sv ***
// self-checking bench for the haptic drive limit register bank
`timescale 1ns/1ps
`default_nettype none
module test_haptic_drive_limit_registers
    import hdl_pkg::*;
();
    // bus address is arbitrary, any seven-bit value works
    localparam logic [6:0] DEV   = 7'h2a;
    localparam int         RES_T [4] = '{500, 1000, 2000, 3000};
    localparam int         ECC_T [4] = '{34, 105, 182, 400};
    logic        sys_clk = 1'b0;
    logic        srst    = 1'b1;
    logic        ce      = 1'b1;
    logic        scl_i   = 1'b1;
    logic        sda_m   = 1'b1;
    logic        ecc     = 1'b0;
    logic        cal     = 1'b0;
    logic        diag    = 1'b0;
    logic        cgw     = 1'b0;
    logic [1:0]  cgc     = 2'h0;
    logic        odp     = 1'b0;
    logic [7:0]  odl     = 8'h00;
    logic [7:0]  vbat    = 8'h00;
    logic [7:0]  th1     = 8'h00;
    logic [7:0]  th2     = 8'h00;
    logic        sda_i;
    logic        sda_o;
    logic        sda_oe_n;
    logic [1:0]  gain;
    logic [1:0]  speed;
    logic [1:0]  src_o;
    logic [11:0] gx100;
    logic [7:0]  clamp_o;
    int          model [int];
    int          num_errors  = 0;
    int          check_count = 0;

    // open drain wire with pull-up: while enabled the device level is wired-and with the host
    assign sda_i = sda_oe_n ? sda_m : (sda_m & sda_o);
    always #2.5 sys_clk = ~sys_clk;

    hdl_drive_limit_regs #(.DEV_ADDR(DEV)) dut (
        .sys_clk(sys_clk), .srst(srst), .ce(ce), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .eccentric_mass_actuator(ecc), .calibration_active(cal), .diagnostics_active(diag),
        .cal_gain_wr(cgw), .cal_gain_code(cgc), .overdrive_phase(odp), .overdrive_limit(odl),
        .battery_voltage_sense(vbat), .battery_threshold_one(th1), .battery_threshold_two(th2),
        .back_emf_amp_gain(gain), .back_emf_gain_x100(gx100), .feedback_loop_speed(speed),
        .drive_clamp(clamp_o), .clamp_source(src_o)
    );

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check_out(input string what, input logic [11:0] seen, input int exp);
        check_count++;
        if (seen !== exp[11:0]) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic check_reg(input logic [7:0] off, input logic [7:0] seen);
        int exp;
        exp = model.exists(off) ? model[off] : 0;
        check_count++;
        if (seen !== exp[7:0]) begin
            num_errors++;
            $display("[ERR] register %0h expected %0h seen %0h", off, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // data moves mid-low so it never races the clock edge through the synchronisers
    task automatic bit_io(input logic b, output logic r);
        tick(3);
        sda_m = b;
        tick(6);
        scl_i = 1'b1;
        tick(3);
        r = sda_i;
        tick(3);
        scl_i = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, nack);
    endtask

    task automatic recv_byte(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask

    task automatic bus_start();
        tick(3);
        sda_m = 1'b1;
        tick(6);
        scl_i = 1'b1;
        tick(6);
        sda_m = 1'b0;
        tick(6);
        scl_i = 1'b0;
    endtask

    task automatic bus_stop();
        tick(3);
        sda_m = 1'b0;
        tick(6);
        scl_i = 1'b1;
        tick(6);
        sda_m = 1'b1;
        tick(6);
    endtask

    task automatic reg_write(input logic [7:0] off, input logic [7:0] d);
        logic n;
        bus_start();
        send_byte({DEV, 1'b0}, n);
        check_out("address ack", {11'h000, n}, 0);
        send_byte(off, n);
        send_byte(d, n);
        bus_stop();
        // unmapped offsets keep reading zero
        if (off >= HDL_ADDR_FEEDBACK_CONTROL && off <= HDL_ADDR_LOW_BAT_TWO) model[off] = d;
    endtask

    task automatic reg_read(input logic [7:0] off);
        logic       n;
        logic [7:0] d;
        bus_start();
        send_byte({DEV, 1'b0}, n);
        send_byte(off, n);
        bus_start();
        send_byte({DEV, 1'b1}, n);
        recv_byte(d, 1'b1);
        bus_stop();
        check_reg(off, d);
    endtask

    task automatic check_gain();
        int f;
        f = model[HDL_ADDR_FEEDBACK_CONTROL];
        check_out("gain code", {10'h000, gain}, f & 3);
        check_out("gain x100", gx100, ecc ? ECC_T[f & 3] : RES_T[f & 3]);
        check_out("loop speed", {10'h000, speed}, (f >> 2) & 3);
    endtask

    task automatic do_reset();
        srst = 1'b1;
        tick(12);
        srst = 1'b0;
        tick(4);
        model.delete();
        model[HDL_ADDR_FEEDBACK_CONTROL] = 8'h36;
        model[HDL_ADDR_STEADY_CLAMP]     = 8'h64;
        model[HDL_ADDR_LOW_BAT_ONE]      = 8'h80;
        model[HDL_ADDR_LOW_BAT_TWO]      = 8'h00;
        for (int a = 'h23; a <= 'h27; a++) reg_read(a[7:0]);
        check_gain();
    endtask

    function automatic int exp_clamp(output int src);
        int od;
        od  = odl;
        src = 0;
        if (!(cal || diag) && vbat < th2) begin
            od  = model[HDL_ADDR_LOW_BAT_TWO];
            src = 2;
        end else if (!(cal || diag) && vbat < th1) begin
            od  = model[HDL_ADDR_LOW_BAT_ONE];
            src = 1;
        end
        if (!odp && model[HDL_ADDR_STEADY_CLAMP] <= od) begin
            od  = model[HDL_ADDR_STEADY_CLAMP];
            src = 3;
        end
        return od;
    endfunction

    initial begin
        #400000;
        num_errors++;
        $display("[ERR] run length expected finish seen hang");
        report_and_stop();
    end

    initial begin
        int src;
        int exp;
        logic n;
        void'($urandom(89));
        do_reset();
        for (int a = 'h23; a <= 'h27; a++) begin
            reg_write(a[7:0], 8'($urandom));
            reg_read(a[7:0]);
        end
        check_gain();
        // every calibration code under both actuator kinds
        for (int c = 0; c < 8; c++) begin
            cgc = c[1:0];
            cgw = 1'b1;
            tick(1);
            cgw = 1'b0;
            ecc = c[2];
            tick(2);
            model[HDL_ADDR_FEEDBACK_CONTROL][1:0] = c[1:0];
            check_gain();
        end
        reg_write(HDL_ADDR_FEEDBACK_CONTROL, 8'h5d);
        check_gain();
        // a foreign address is refused and leaves the registers alone
        bus_start();
        send_byte({DEV ^ 7'h01, 1'b0}, n);
        check_out("foreign address ack", {11'h000, n}, 1);
        send_byte(HDL_ADDR_STEADY_CLAMP, n);
        send_byte(8'h00, n);
        bus_stop();
        reg_read(HDL_ADDR_STEADY_CLAMP);
        // two data bytes in one frame: the pointer steps to the next register
        bus_start();
        send_byte({DEV, 1'b0}, n);
        send_byte(HDL_ADDR_STEADY_CLAMP, n);
        send_byte(8'h3c, n);
        send_byte(8'h5a, n);
        bus_stop();
        model[HDL_ADDR_STEADY_CLAMP] = 'h3c;
        model[HDL_ADDR_LOW_BAT_ONE]  = 'h5a;
        reg_read(HDL_ADDR_STEADY_CLAMP);
        reg_read(HDL_ADDR_LOW_BAT_ONE);
        for (int i = 0; i < 300; i++) begin
            odp  = 1'($urandom);
            odl  = 8'($urandom);
            vbat = 8'($urandom);
            th1  = (i % 7 == 0) ? vbat : 8'($urandom);
            th2  = (i % 11 == 0) ? vbat : 8'($urandom);
            cal  = ($urandom % 4) == 0;
            diag = ($urandom % 5) == 0;
            tick(1);
            exp = exp_clamp(src);
            check_out("drive clamp", {4'h0, clamp_o}, exp);
            check_out("clamp source", {10'h000, src_o}, src);
            // clock enable low: new inputs must not reach the outputs
            if (i % 50 == 25) begin
                ce  = 1'b0;
                odp = ~odp;
                odl = ~odl;
                tick(3);
                check_out("frozen clamp", {4'h0, clamp_o}, exp);
                check_out("frozen source", {10'h000, src_o}, src);
                ce  = 1'b1;
            end
            if (i % 60 == 59)
                for (int a = 'h23; a <= 'h26; a++) reg_write(a[7:0], 8'($urandom));
        end
        do_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
